// [verilog/ebws_ctrl.sv]
// External bus timing controller: wait-state generator, bank-switch gap
// insertion, bus keepers and bus-off control, with its control registers.
// Assumes the core raises one request at a time and waits for done; the
// hardware ready line is not handled here.
`timescale 1ns/1ps

module ebws_ctrl
  import ebws_pkg::*;
(
  input  wire logic        clk_sys,          // System clock
  input  wire logic        reset,            // Async, active high
  input  wire ebws_rbus_s  rbus,             // Register port
  output      logic [15:0] reg_rdata,        // Read data, next cycle
  input  wire ebws_acc_s   acc,              // Core access request
  output      logic        acc_ready,        // Request may be taken
  output      logic        acc_done,         // Access finished pulse
  output      logic [15:0] acc_rdata,        // Data of a finished read
  output      ebws_ext_s   ext,              // External bus outputs
  input  wire logic [15:0] ext_data_i,       // External data bus level
  input  wire logic [7:0]  host_data_pins_i, // Host data bus level
  input  wire logic        host_data_driven, // Host bus driven elsewhere
  output      logic [7:0]  host_data_pins_o, // Keeper drive value
  output      logic        host_data_pins_oe,// Keeper drives host bus
  output      logic        data_rom_map,     // Mode bit
  output      logic        micro_mode_sel,   // Mode bit
  output      logic        ram_overlay,      // Mode bit
  output      logic        hold_mode,        // Mode bit
  output      logic        bus_is_off        // External bus switched off
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    ebws_state_e st;     // Sequencer state
    logic [3:0]  cnt;    // Remaining wait cycles
    ebws_acc_s   cur;    // Latched request
    logic [19:0] p_addr; // Previous access address
    ebws_space_e p_sp;   // Previous access space
    logic        p_rd;   // Previous access was a read
    logic        p_vld;  // A previous access exists
    logic [15:0] wsc;    // Wait configuration
    logic [15:0] bsc;    // Bank switch control
    logic        dbl;    // Wait doubling
    logic [3:0]  pm;     // Mode bits
    logic [15:0] rdata;  // Register read data
    logic        done;   // Done pulse
    logic [15:0] adata;  // Access read data
    logic        ready;  // Ready to take a request
    logic        off;    // Bus off in force
    ebws_ext_s   ext;    // External bus drive
    logic [15:0] dhold;  // Last data bus level
    logic [7:0]  hhold;  // Last host bus level
    logic        hoe;    // Host keeper drive
  } ebws_st_s;

  ebws_st_s s_q;  // Registered state
  ebws_st_s s_d;  // Next state

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Base wait count for one access
  function automatic logic [2:0] base_wait(
    input ebws_space_e sp,
    input logic [19:0] a,
    input logic [15:0] w
  );
    logic [2:0] r;
    r = w[WSC_PL_LSB +: 3];
    case (sp)
      SP_IO: begin
        r = w[WSC_IO_LSB +: 3]; // RL1
      end
      SP_DATA: begin
        if (a[15]) begin
          r = w[WSC_DU_LSB +: 3]; // RL2
        end else begin
          r = w[WSC_DL_LSB +: 3]; // RL3
        end
      end
      SP_PROG: begin
        // Range select decides how program fields map
        if (w[WSC_XPA]) begin
          r = w[WSC_PL_LSB +: 3]; // RL5 RL6 RL7
        end else if (a[15]) begin
          r = w[WSC_PU_LSB +: 3]; // RL4
        end else begin
          r = w[WSC_PL_LSB +: 3]; // RL6
        end
      end
      default: begin
        r = w[WSC_PL_LSB +: 3];
      end
    endcase
    return r;
  endfunction : base_wait

  // Whether a gap cycle precedes this access. I/O space has no banks, and
  // the first access after reset never pays a gap because there is no
  // previous address to compare against.
  function automatic logic need_gap(
    input ebws_acc_s   a,
    input logic [19:0] pa,
    input ebws_space_e psp,
    input logic        prd,
    input logic        pv,
    input logic [15:0] b
  );
    logic [3:0] diff;
    logic       g;
    diff = (a.addr[15:12] ^ pa[15:12]) & b[BSC_MSK_LSB +: 4]; // RL12
    g    = 1'b0;
    if (pv) begin
      // Crossing a bank inside program or data space
      if (a.space == psp && a.space != SP_IO) begin
        if (diff != 4'h0) begin
          g = 1'b1; // RL10
        end
        // Program pages are separate banks as well
        if (a.space == SP_PROG && a.addr[19:16] != pa[19:16]) begin
          g = 1'b1; // RL10
        end
      end
      // Moving from data space into program space
      if (psp == SP_DATA && a.space == SP_PROG) begin
        g = 1'b1; // RL11
      end
      // Read turnaround between program and data
      if (b[BSC_TURN] && a.rd && prd) begin
        if ((psp == SP_PROG && a.space == SP_DATA) ||
            (psp == SP_DATA && a.space == SP_PROG)) begin
          g = 1'b1; // RL13
        end
      end
    end
    return g;
  endfunction : need_gap

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic [2:0] bw;
    logic [3:0] waits;
    logic       take;
    ebws_acc_s  src;
    bw    = 3'h0;
    waits = 4'h0;
    take  = 1'b0;
    src   = '0;
    s_d   = s_q;
    s_d.done = 1'b0;

    // Register writes; reserved bits never change
    // A write lands at the edge that samples its strobe
    if (rbus.wr) begin
      case (rbus.addr)
        REG_WAIT_CFG: begin
          s_d.wsc = rbus.wdata;
        end
        REG_BANK_SW: begin
          s_d.bsc = rbus.wdata & BSC_WMASK; // RL9
        end
        REG_WAIT_MUL: begin
          s_d.dbl = rbus.wdata[0]; // RL9
        end
        REG_PROC_BITS: begin
          // Mode bits are frozen while the bus is off
          if (!s_q.off) begin
            s_d.pm = rbus.wdata[3:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (s_q.off) begin
      s_d.pm = s_q.pm; // RL17
    end

    // Register reads answer the next cycle; unmapped reads give zero
    // A read beside a write to the same register returns the old value
    s_d.rdata = 16'h0000;
    if (rbus.rd) begin
      case (rbus.addr)
        REG_WAIT_CFG:  s_d.rdata = s_q.wsc;
        REG_BANK_SW:   s_d.rdata = s_q.bsc;
        REG_WAIT_MUL:  s_d.rdata = {15'h0000, s_q.dbl}; // RL9
        REG_PROC_BITS: s_d.rdata = {12'h000, s_q.pm};
        default:       s_d.rdata = 16'h0000;
      endcase
    end

    // Wait count of the request being taken, or of the latched one after a
    // gap, doubled when asked. A wait field written in the same cycle as a
    // take is seen by that access only if a gap cycle comes first; software must settle it first.
    src   = (s_q.st == ST_IDLE) ? acc : s_q.cur;
    bw    = base_wait(src.space, src.addr, s_q.wsc);
    waits = s_q.dbl ? {bw, 1'b0} : {1'b0, bw}; // RL8

    // Access sequencer. A taken request spends one cycle in the gap state
    // when a bank or space switch needs it, then holds the strobe for one
    // cycle plus the programmed waits. Done rises in the cycle after the
    // last strobe cycle, and a new request may be taken in that cycle.
    // Devices slower than fourteen waits must stretch the cycle on the
    // ready line, which this block does not watch.
    case (s_q.st)
      ST_IDLE: begin
        // Refused requests leave no trace
        take = acc.req && s_q.ready;
        if (take) begin
          s_d.cur = acc;
          if (need_gap(acc, s_q.p_addr, s_q.p_sp, s_q.p_rd, s_q.p_vld,
                       s_q.bsc)) begin
            // Gap is spent before the programmed waits
            s_d.st  = ST_SWITCH; // RL20
            s_d.cnt = SWITCH_CYCLES - 4'h1;
          end else begin
            s_d.st  = ST_ACCESS;
            s_d.cnt = waits; // RL20
          end
        end
      end
      ST_SWITCH: begin
        // Strobe stays inactive during the gap; address and space select are driven
        if (s_q.cnt == 4'h0) begin
          s_d.st  = ST_ACCESS;
          s_d.cnt = waits; // RL20
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      ST_ACCESS: begin
        // Count holds the waits still to run; the strobe ends at zero
        if (s_q.cnt == 4'h0) begin
          s_d.st   = ST_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1; // RL20
        end
        if (s_d.done) begin
          s_d.adata  = s_q.cur.rd ? ext_data_i : s_q.adata;
          s_d.dhold  = s_q.cur.rd ? ext_data_i : s_q.cur.wdata;
          s_d.p_addr = s_q.cur.addr;
          s_d.p_sp   = s_q.cur.space;
          s_d.p_rd   = s_q.cur.rd;
          s_d.p_vld  = 1'b1;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Bus off only takes hold once no cycle is in progress, so a request
    // taken in the same cycle as the write still runs to its end. While
    // off, requests are refused by holding ready low.
    s_d.off   = s_d.bsc[BSC_OFF] && (s_d.st == ST_IDLE); // RL16
    s_d.ready = (s_d.st == ST_IDLE) && !s_d.off;

    // External bus drive for the coming cycle
    s_d.ext        = '0;
    s_d.ext.ps_n   = 1'b1;
    s_d.ext.ds_n   = 1'b1;
    s_d.ext.is_n   = 1'b1;
    s_d.ext.rw     = 1'b1;
    s_d.ext.strb_n = 1'b1;
    if (!s_d.off && s_d.st != ST_IDLE) begin
      s_d.ext.addr = s_d.cur.addr;
      s_d.ext.rw   = s_d.cur.rd;
      s_d.ext.ps_n = s_d.cur.space != SP_PROG;
      s_d.ext.ds_n = s_d.cur.space != SP_DATA;
      s_d.ext.is_n = s_d.cur.space != SP_IO;
    end
    if (s_d.st == ST_ACCESS) begin
      // Strobe spans the access cycle and all its waits
      s_d.ext.strb_n = 1'b0;
      if (!s_d.cur.rd) begin
        s_d.ext.dout    = s_d.cur.wdata;
        s_d.ext.dout_oe = 1'b1;
      end
    end
    // Data keeper holds the last level whenever nobody else drives. It
    // stays off while a read strobe is out so it never fights the device.
    if (s_d.bsc[BSC_DBK] && !s_d.ext.dout_oe &&
        !(s_d.st == ST_ACCESS && s_d.cur.rd)) begin
      s_d.ext.dout    = s_d.dhold; // RL15
      s_d.ext.dout_oe = 1'b1;      // RL15
    end

    // Host keeper follows the bus while driven, holds it otherwise
    // It yields the cycle after another driver appears
    if (host_data_driven) begin
      s_d.hhold = host_data_pins_i;
    end
    s_d.hoe = s_d.bsc[BSC_HBK] && !host_data_driven; // RL14
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Reset gives seven waits on every range and a quiet bus
  // The asynchronous branch loads constants only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q            <= '0;
      s_q.st         <= ST_IDLE;
      s_q.wsc        <= WSC_RESET; // RL18
      s_q.bsc        <= BSC_RESET;
      s_q.dbl        <= MUL_RESET;
      s_q.pm         <= PM_RESET;
      s_q.ready      <= 1'b1;
      s_q.ext.ps_n   <= 1'b1;
      s_q.ext.ds_n   <= 1'b1;
      s_q.ext.is_n   <= 1'b1;
      s_q.ext.rw     <= 1'b1;
      s_q.ext.strb_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  // so no output has a combinational path from an input

  assign reg_rdata         = s_q.rdata;
  assign acc_ready         = s_q.ready;
  assign acc_done          = s_q.done;
  assign acc_rdata         = s_q.adata;
  assign ext               = s_q.ext;
  assign host_data_pins_o  = s_q.hhold;
  assign host_data_pins_oe = s_q.hoe;
  assign data_rom_map      = s_q.pm[PM_DATA_ROM_MAP];
  assign micro_mode_sel    = s_q.pm[PM_MPMC];
  assign ram_overlay       = s_q.pm[PM_RAM_OVERLAY];
  assign hold_mode         = s_q.pm[PM_HOLD];
  assign bus_is_off        = s_q.off;

endmodule : ebws_ctrl

// [verilog/ebws_pkg.sv]
// Constants, types and carriers for the external bus wait-state and
// bank-switch controller. Assumes a single 50 MHz system clock.
//
// How it works
// [RL1] I/O accesses use the I/O wait field
// [RL2] Upper data half uses upper-data field
// [RL3] Lower data half uses lower-data field
// [RL4] Range select 0: upper program field, upper half
// [RL5] Range select 1: upper program field ignored
// [RL6] Lower program field: lower half, or all
// [RL7] Bit 15 holds the program range select
// [RL8] Doubling bit multiplies waits by two
// [RL9] Reserved control bits read zero, ignore writes
// [RL10] Bank crossing in one space adds cycle
// [RL11] Data to program crossing adds cycle
// [RL12] Four-bit mask picks compared address bits
// [RL13] Turnaround bit adds cycle between reads
// [RL14] Host bus keeper holds undriven host bus
// [RL15] Data bus keeper holds undriven data bus
// [RL16] Bus off after current cycle completes
// [RL17] Bus off locks mode bit writes
// [RL18] Reset gives seven waits everywhere
// [RL19] Slow devices extend through ready line; this block does not watch it
// [RL20] Waits plus separate bank-switch cycle
package ebws_pkg;

  // Register offsets
  localparam logic [7:0]  REG_WAIT_CFG  = 8'h28;
  localparam logic [7:0]  REG_BANK_SW   = 8'h29;
  localparam logic [7:0]  REG_WAIT_MUL  = 8'h2b;
  localparam logic [7:0]  REG_PROC_BITS = 8'h30;

  // Values after reset
  localparam logic [15:0] WSC_RESET = 16'h7fff; // All wait fields seven, range select zero
  localparam logic [15:0] BSC_RESET = 16'hf800;
  localparam logic        MUL_RESET = 1'b0;
  localparam logic [3:0]  PM_RESET  = 4'h0;

  // Field positions
  localparam int WSC_XPA    = 15;
  localparam int WSC_IO_LSB = 12;
  localparam int WSC_DU_LSB = 9;
  localparam int WSC_DL_LSB = 6;
  localparam int WSC_PU_LSB = 3;
  localparam int WSC_PL_LSB = 0;
  localparam int BSC_MSK_LSB = 12;
  localparam int BSC_TURN   = 11;
  localparam int BSC_HBK    = 2;
  localparam int BSC_DBK    = 1;
  localparam int BSC_OFF    = 0;
  localparam logic [15:0] BSC_WMASK = 16'hf807; // Writable bits
  localparam int PM_DATA_ROM_MAP = 0;
  localparam int PM_MPMC = 1;
  localparam int PM_RAM_OVERLAY = 2;
  localparam int PM_HOLD = 3;

  // Cycles spent in one bank-switch gap
  localparam logic [3:0] SWITCH_CYCLES = 4'h1;

  typedef enum logic [1:0] {SP_PROG, SP_DATA, SP_IO} ebws_space_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SWITCH, ST_ACCESS} ebws_state_e;

  // Register port from software
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ebws_rbus_s;

  // Access request from the core
  typedef struct packed {
    logic        req;
    ebws_space_e space;
    logic        rd;
    logic [19:0] addr;
    logic [15:0] wdata;
  } ebws_acc_s;

  // External bus outputs, strobes active low
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dout;
    logic        dout_oe;
    logic        ps_n;
    logic        ds_n;
    logic        is_n;
    logic        rw;
    logic        strb_n;
  } ebws_ext_s;

endpackage : ebws_pkg

// [tb/ebws_mem.sv]
// External memory model on the far side of the bus.
// Assumes low-active strobes; contents follow the address.
`timescale 1ns/1ps

module ebws_mem
  import ebws_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire ebws_ext_s   ext,
  output      logic [15:0] ext_data_i
);
  logic [15:0] last_q = 16'h0000; // Level seen last cycle

  // Fast device: answers within the strobe, never needs the ready line
  always_comb begin
    if (ext.dout_oe) begin
      ext_data_i = ext.dout;
    end else if (!ext.strb_n && ext.rw) begin
      ext_data_i = ext.addr[15:0] ^ 16'h5a5a;
    end else begin
      ext_data_i = ~last_q; // Released bus must not look held
    end
  end

  always_ff @(posedge clk_sys) begin
    last_q <= ext_data_i;
  end
endmodule : ebws_mem

// [tb/ebws_chk.sv]
// Port checker for the wait-state and bank-switch controller.
// Assumes it is bound to ebws_ctrl and sees its ports only.
`timescale 1ns/1ps

module ebws_chk
  import ebws_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire ebws_rbus_s  rbus,
  input wire logic [15:0] reg_rdata,
  input wire ebws_acc_s   acc,
  input wire logic        acc_ready,
  input wire logic        acc_done,
  input wire ebws_ext_s   ext,
  input wire logic        host_data_driven,
  input wire logic [7:0]  host_data_pins_o,
  input wire logic        host_data_pins_oe,
  input wire logic        data_rom_map,
  input wire logic        micro_mode_sel,
  input wire logic        ram_overlay,
  input wire logic        hold_mode,
  input wire logic        bus_is_off
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire [3:0] mode_w = {hold_mode, ram_overlay, micro_mode_sel, data_rom_map}; // Mode bits

  AST_MUL_RSV: assert property (rbus.rd && rbus.addr == REG_WAIT_MUL
    |=> reg_rdata[15:1] == 15'h0) else $error("multiplier reserved bits set");
  AST_BSC_RSV: assert property (rbus.rd && rbus.addr == REG_BANK_SW
    |=> reg_rdata[10:3] == 8'h00) else $error("bank reserved bits set");
  AST_OFF_IDLE: assert property (bus_is_off |-> ext.strb_n && ext.ps_n && ext.ds_n
    && ext.is_n && ext.addr == 20'h0) else $error("bus active while off");
  AST_MODE_LOCK: assert property (bus_is_off && rbus.wr && rbus.addr == REG_PROC_BITS
    |=> $stable(mode_w)) else $error("mode bits changed while off");
  AST_DONE_WIN: assert property (acc.req && acc_ready |=> !acc_done ##[1:16] acc_done)
    else $error("access length out of range");
  AST_DONE_STRB: assert property (acc_done |-> ext.strb_n && acc_ready)
    else $error("strobe low at access end");
  AST_ONE_SEL: assert property (!ext.strb_n |-> $onehot({!ext.ps_n, !ext.ds_n, !ext.is_n}))
    else $error("space selects not one-hot");
  AST_HOST_KEEP: assert property (host_data_pins_oe && $past(host_data_pins_oe)
    |-> $stable(host_data_pins_o)) else $error("host keeper value moved");
  AST_HOST_YIELD: assert property (host_data_driven |=> !host_data_pins_oe)
    else $error("host keeper fights driver");
  CVR_DONE: cover property (acc_done);
  CVR_OFF: cover property (bus_is_off);
  CVR_KEEP: cover property (host_data_pins_oe);
endmodule : ebws_chk

bind ebws_ctrl ebws_chk u_chk (.clk_sys(clk_sys), .reset(reset), .rbus(rbus),
  .reg_rdata(reg_rdata), .acc(acc), .acc_ready(acc_ready), .acc_done(acc_done), .ext(ext),
  .host_data_driven(host_data_driven), .host_data_pins_o(host_data_pins_o),
  .host_data_pins_oe(host_data_pins_oe), .data_rom_map(data_rom_map),
  .micro_mode_sel(micro_mode_sel), .ram_overlay(ram_overlay), .hold_mode(hold_mode),
  .bus_is_off(bus_is_off));

// [tb/ext_bus_wait_state_bank_switch_tb.sv]
// Bench: register checks, timed accesses, keepers and bus-off.
// Assumes ebws_mem on the bus; shadows predict wait counts.
`timescale 1ns/1ps

module ext_bus_wait_state_bank_switch_tb;
  import ebws_pkg::*;
  logic        clk_sys = 1'b0, reset = 1'b1, host_data_driven = 1'b1;
  ebws_rbus_s  rbus = '0;
  ebws_acc_s   acc = '0;
  ebws_ext_s   ext;
  logic [15:0] reg_rdata, acc_rdata, ext_data_i, lw;
  logic [15:0] cfg = 16'h7fff, bsc = 16'hf800, lf = 16'h6173; // Shadows, seed
  logic [7:0]  host_data_pins_i, host_data_pins_o, hval = 8'h3c;
  logic        acc_ready, acc_done, host_data_pins_oe, bus_is_off, dbl = 1'b0;
  logic        pv = 1'b0, prd;
  logic [19:0] pa;
  ebws_space_e psp;
  wire  [3:0]  md;
  int          n_mismatch = 0, total_checks = 0, cyc = 0;

  // Host bus wire: other driver, else our keeper, else the inverse of hval
  assign host_data_pins_i = host_data_driven ? hval : host_data_pins_oe ? host_data_pins_o : ~hval;

  ebws_ctrl u_dut (.clk_sys(clk_sys), .reset(reset), .rbus(rbus), .reg_rdata(reg_rdata),
    .acc(acc), .acc_ready(acc_ready), .acc_done(acc_done), .acc_rdata(acc_rdata),
    .ext(ext), .ext_data_i(ext_data_i), .host_data_pins_i(host_data_pins_i),
    .host_data_driven(host_data_driven), .host_data_pins_o(host_data_pins_o),
    .host_data_pins_oe(host_data_pins_oe), .data_rom_map(md[0]), .micro_mode_sel(md[1]),
    .ram_overlay(md[2]), .hold_mode(md[3]), .bus_is_off(bus_is_off));
  ebws_mem u_mem (.clk_sys(clk_sys), .ext(ext), .ext_data_i(ext_data_i));

  always #10 clk_sys = ~clk_sys;

  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    rbus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    rbus.wr <= 1'b0;
    if (a == REG_WAIT_CFG) cfg = d;
    if (a == REG_BANK_SW) bsc = d & BSC_WMASK;
    if (a == REG_WAIT_MUL) dbl = d[0];
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    rbus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    rbus.rd <= 1'b0;
    #1 chk(reg_rdata, e, "register read");
  endtask : rdc

  // Next value of the stimulus shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  // Expected cycles from taking edge to done: 1 + gap + waits
  function automatic logic [15:0] xcyc(input ebws_space_e s, input logic r, input logic [19:0] a);
    logic [3:0] b;
    logic       g;
    g = pv && ((s == psp && s != SP_IO && ((((a[15:12] ^ pa[15:12]) & bsc[15:12]) != 4'h0)
        || (s == SP_PROG && a[19:16] != pa[19:16]))) || (psp == SP_DATA && s == SP_PROG)
        || (bsc[11] && r && prd && s != psp && s != SP_IO && psp != SP_IO));
    case (s)
      SP_IO:   b = {1'b0, cfg[14:12]};
      SP_DATA: b = {1'b0, a[15] ? cfg[11:9] : cfg[8:6]};
      default: b = {1'b0, (a[15] && !cfg[15]) ? cfg[5:3] : cfg[2:0]};
    endcase
    if (dbl) b = b << 1;
    return 16'(1 + g + b);
  endfunction : xcyc

  task automatic go(input ebws_space_e s, input logic r, input logic [19:0] a);
    logic [15:0] e;
    int          c;
    e = xcyc(s, r, a);
    lw = lf;
    @(posedge clk_sys);
    acc <= '{1'b1, s, r, a, lf};
    @(posedge clk_sys);
    acc.req <= 1'b0;
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (acc_done !== 1'b1 && c < 40);
    chk(16'(c), e, "access cycles");
    if (r) chk(acc_rdata, a[15:0] ^ 16'h5a5a, "read data");
    pv = 1'b1;
    psp = s;
    pa = a;
    prd = r;
  endtask : go

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rdc(REG_WAIT_CFG, 16'h7fff);
    rdc(REG_BANK_SW, 16'hf800);
    rdc(REG_WAIT_MUL, 16'h0000);
    rdc(8'h00, 16'h0000);
    go(SP_IO, 1'b1, 20'h01234);
    wr(REG_WAIT_MUL, 16'hffff);
    rdc(REG_WAIT_MUL, 16'h0001);
    go(SP_DATA, 1'b1, 20'h0f000);
    wr(REG_BANK_SW, 16'hfffe);
    rdc(REG_BANK_SW, 16'hf806);
    @(posedge clk_sys);
    host_data_driven <= 1'b0;
    go(SP_DATA, 1'b0, 20'h00010);
    @(posedge clk_sys);
    #1 chk({ext.dout_oe, ext.dout[14:0]}, {1'b1, lw[14:0]}, "data keeper");
    chk(ext.dout, lw, "data keeper value");
    chk({7'h00, host_data_pins_oe, host_data_pins_o}, 16'h013c, "host keeper");
    wr(REG_PROC_BITS, 16'h0005);
    wr(REG_BANK_SW, 16'hf801);
    repeat (2) @(posedge clk_sys);
    #1 chk({15'h0, bus_is_off}, 16'h0001, "bus off");
    wr(REG_PROC_BITS, 16'h000a);
    rdc(REG_PROC_BITS, 16'h0005);
    wr(REG_BANK_SW, 16'hf800);
    wr(REG_PROC_BITS, 16'h000a);
    rdc(REG_PROC_BITS, 16'h000a);
    chk({11'h0, host_data_pins_oe, md}, 16'h000a, "keeper off, mode");
    // Random configs and accesses cover every space, half and bank, and pages 0 to 3
    for (int i = 0; i < 80; i++) begin
      lf = lfsr_next(lf);
      if (lf[3:0] == 4'h0) wr(REG_WAIT_CFG, lf);
      if (lf[3:0] == 4'h1) wr(REG_WAIT_MUL, {15'h0, lf[9]});
      if (lf[3:0] == 4'h2) wr(REG_BANK_SW, {lf[15:11], 11'h000});
      go(ebws_space_e'((lf[5:4] == 2'h3) ? 2'h0 : lf[5:4]), lf[6], {2'h0, lf[8:7], lf});
    end
    conclude();
  end
endmodule : ext_bus_wait_state_bank_switch_tb
